// ==== ccpcu_pkg.sv ====
package ccpcu_pkg;
    // register word offsets on the plain register port
    localparam logic [3:0] CCPCU_ADDR_CONTROL = 4'h0;
    localparam logic [3:0] CCPCU_ADDR_CAPT_LOW = 4'h1;
    localparam logic [3:0] CCPCU_ADDR_CAPT_HIGH = 4'h2;
    localparam logic [3:0] CCPCU_ADDR_FLAGS = 4'h3;
    localparam logic [3:0] CCPCU_ADDR_ENABLE = 4'h4;
    localparam logic [3:0] CCPCU_ADDR_CLEAR = 4'h5;
    localparam logic [3:0] CCPCU_ADDR_STATUS = 4'h6;

    // control register layout
    localparam int CCPCU_MODE_LSB = 0;
    localparam int CCPCU_MODE_MSB = 3;
    localparam int CCPCU_DUTY_LSB = 4;
    localparam int CCPCU_DUTY_MSB = 5;
    localparam logic [7:0] CCPCU_CONTROL_RESET = 8'h00;
    localparam logic [7:0] CCPCU_CONTROL_MASK = 8'h3f;

    // flag bit of the capture event in flag, enable and clear registers
    localparam int CCPCU_FLAG_CAPTURE = 0;

    // mode select encodings
    localparam logic [3:0] CCPCU_MODE_OFF = 4'h0;
    localparam logic [3:0] CCPCU_MODE_FALL = 4'h4;
    localparam logic [3:0] CCPCU_MODE_RISE = 4'h5;
    localparam logic [3:0] CCPCU_MODE_RISE4 = 4'h6;
    localparam logic [3:0] CCPCU_MODE_RISE16 = 4'h7;

    // prescaler counts
    localparam logic [3:0] CCPCU_PRE4_LAST = 4'h3;
    localparam logic [3:0] CCPCU_PRE16_LAST = 4'hf;
    localparam logic [3:0] CCPCU_PRE_ZERO = 4'h0;
    localparam logic [3:0] CCPCU_PRE_ONE = 4'h1;
endpackage

// ==== ccpcu_sync_edge.sv ====
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser of the pin followed by edge detection
module ccpcu_sync_edge (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_in,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // first flop feeds only the second flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // edges are seen on the synchronised level only
    assign rise = sync_q & ~last_q;
    assign fall = ~sync_q & last_q;
endmodule
`default_nettype wire

// ==== ccpcu_capture_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
// Function
// RQ1 - each capture event copies all 16 bits of timer one into capture pair
// RQ2 - events: every falling, every rising, every 4th or 16th rising edge
// RQ3 - mode 0100 captures falling edges, mode 0101 rising edges
// RQ4 - a capture sets the capture interrupt flag
// RQ5 - flag stays set until software clears it; hardware never clears it
// RQ6 - a new capture overwrites an unread captured value
// RQ7 - pin driven as output can still cause captures from its own level
// RQ8 - software should make the pin an input while capturing
// RQ9 - timer one must run synchronously for captures to work
// RQ10 - mode changes may raise a false capture; software clears the flag
// RQ11 - prescaler counter held clear when off or not capturing
// RQ12 - any reset clears the prescaler counter
// RQ13 - switching prescale settings does not clear the prescaler counter
// RQ14 - software should zero control before selecting a new prescale
// RQ15 - control bits 5-4 hold the two low pwm duty bits
// RQ16 - control bits 3-0 are the mode select field
// RQ17 - pin is synchronised and edge detected before the prescaler
// RQ18 - mode zero turns the unit off and clears capture state
module ccpcu_capture_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [15:0] timer_one_count,
    input wire logic capture_pin_in,
    output logic capture_pin_out,
    output logic capture_pin_oe,
    output logic [3:0] mode_select_field,
    output logic [1:0] pwm_duty_low_bits,
    output logic irq
);
    import ccpcu_pkg::*;

    // ****************************************
    // registers and decode
    // ****************************************
    logic [7:0] control_q;
    logic [15:0] capture_q;
    logic flag_q;
    logic enable_q;
    logic [3:0] pre_q;
    logic [3:0] pre_d;
    logic [7:0] rdata_q;
    logic edge_rise;
    logic edge_fall;
    logic capture_mode;
    logic capture_event;
    logic mode_off;
    logic wr_control;
    logic wr_clear;
    logic wr_enable;

    assign wr_control = reg_wr && (reg_addr == CCPCU_ADDR_CONTROL);
    assign wr_clear = reg_wr && (reg_addr == CCPCU_ADDR_CLEAR);
    assign wr_enable = reg_wr && (reg_addr == CCPCU_ADDR_ENABLE);

    // RQ16 mode field decode
    assign mode_select_field = control_q[CCPCU_MODE_MSB:CCPCU_MODE_LSB];
    // RQ15 duty low bits
    assign pwm_duty_low_bits = control_q[CCPCU_DUTY_MSB:CCPCU_DUTY_LSB];
    assign mode_off = (mode_select_field == CCPCU_MODE_OFF);
    assign capture_mode = (mode_select_field == CCPCU_MODE_FALL) || (mode_select_field == CCPCU_MODE_RISE)
        || (mode_select_field == CCPCU_MODE_RISE4) || (mode_select_field == CCPCU_MODE_RISE16);

    // capture never drives the pin; capture_pin_out and capture_pin_oe are tied low in every mode
    assign capture_pin_out = 1'b0;
    assign capture_pin_oe = 1'b0;

    // ****************************************
    // control register
    // ****************************************
    // unimplemented bits 7-6 are never stored, so they read zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            control_q <= CCPCU_CONTROL_RESET;
        end else if (wr_control) begin
            control_q <= reg_wdata & CCPCU_CONTROL_MASK;
        end
    end

    // ****************************************
    // edge detection and prescaler
    // ****************************************
    // RQ17 sync then edge
    // RQ7 the pad reflects our own output level too, so it is always sampled
    ccpcu_sync_edge u_sync (
        .clk(clk),
        .rst(rst),
        .pin_in(capture_pin_in),
        .rise(edge_rise),
        .fall(edge_fall)
    );

    // RQ2 edge selection and prescale
    always_comb begin
        pre_d = pre_q;
        capture_event = 1'b0;
        if (!capture_mode) begin
            // RQ11 held clear when idle
            pre_d = CCPCU_PRE_ZERO;
        end else begin
            case (mode_select_field)
                // RQ3 falling edge mode
                CCPCU_MODE_FALL: begin
                    capture_event = edge_fall;
                end
                CCPCU_MODE_RISE: begin
                    capture_event = edge_rise;
                end
                CCPCU_MODE_RISE4: begin
                    if (edge_rise) begin
                        // RQ13 count kept across prescale changes
                        capture_event = (pre_q[1:0] == CCPCU_PRE4_LAST[1:0]);
                        pre_d = pre_q + CCPCU_PRE_ONE;
                    end
                end
                CCPCU_MODE_RISE16: begin
                    if (edge_rise) begin
                        capture_event = (pre_q == CCPCU_PRE16_LAST);
                        pre_d = pre_q + CCPCU_PRE_ONE;
                    end
                end
                default: begin
                    capture_event = 1'b0;
                end
            endcase
        end
    end

    // RQ12 reset clears counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_q <= CCPCU_PRE_ZERO;
        end else begin
            pre_q <= pre_d;
        end
    end

    // ****************************************
    // capture register pair
    // ****************************************
    // RQ1 full timer copy
    // RQ6 newest capture wins; RQ18 off mode clears the pair
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capture_q <= 16'h0000;
        end else if (mode_off) begin
            capture_q <= 16'h0000;
        end else if (capture_event) begin
            capture_q <= timer_one_count;
        end
    end

    // ****************************************
    // interrupt flag, enable, output
    // ****************************************
    // RQ4 capture sets flag
    // RQ5 only software clears; set beats clear in the same cycle
    // RQ10 mode changes may set it falsely; software clears it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (capture_event) begin
            flag_q <= 1'b1;
        end else if (wr_clear && reg_wdata[CCPCU_FLAG_CAPTURE]) begin
            flag_q <= 1'b0;
        end
    end

    // interrupt enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_q <= 1'b0;
        end else if (wr_enable) begin
            enable_q <= reg_wdata[CCPCU_FLAG_CAPTURE];
        end
    end

    assign irq = flag_q & enable_q;

    // ****************************************
    // read port
    // ****************************************
    // data appears one cycle after the strobe and only then
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                CCPCU_ADDR_CONTROL: rdata_q <= control_q;
                CCPCU_ADDR_CAPT_LOW: rdata_q <= capture_q[7:0];
                CCPCU_ADDR_CAPT_HIGH: rdata_q <= capture_q[15:8];
                CCPCU_ADDR_FLAGS: rdata_q <= {7'h00, flag_q};
                CCPCU_ADDR_ENABLE: rdata_q <= {7'h00, enable_q};
                CCPCU_ADDR_STATUS: rdata_q <= {4'h0, pre_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // ****************************************
    // assertions
    // ****************************************
    sequence s_event_seen;
        capture_event && !mode_off;
    endsequence

    AST_CAPT_COPY: assert property (@(posedge clk) disable iff (rst) // RQ1
        s_event_seen |=> capture_q == $past(timer_one_count)) else $error("capture value not copied");
    AST_FLAG_SET: assert property (@(posedge clk) disable iff (rst) // RQ4
        capture_event |=> flag_q) else $error("flag not set on capture");
    AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (rst) // RQ5
        flag_q && !(wr_clear && reg_wdata[CCPCU_FLAG_CAPTURE]) |=> flag_q) else $error("flag dropped by hardware");
    AST_PRE_IDLE: assert property (@(posedge clk) disable iff (rst) // RQ11
        !capture_mode |=> pre_q == CCPCU_PRE_ZERO) else $error("prescaler not cleared");
    AST_FALL_MODE: assert property (@(posedge clk) disable iff (rst) // RQ3
        mode_select_field == CCPCU_MODE_FALL && edge_rise |-> !capture_event) else $error("rise captured in fall mode");
    AST_RISE_MODE: assert property (@(posedge clk) disable iff (rst) // RQ3
        mode_select_field == CCPCU_MODE_RISE && edge_rise |-> capture_event) else $error("rise edge missed");
    AST_PRE16: assert property (@(posedge clk) disable iff (rst) // RQ2
        capture_event && mode_select_field == CCPCU_MODE_RISE16 |-> pre_q == CCPCU_PRE16_LAST)
        else $error("16th edge wrong");
    AST_PRE_KEEP: assert property (@(posedge clk) disable iff (rst) // RQ13
        capture_mode && !edge_rise |=> pre_q == $past(pre_q) || !capture_mode) else $error("prescaler lost count");
    AST_OFF_CLEAR: assert property (@(posedge clk) disable iff (rst) // RQ18
        mode_off |=> capture_q == 16'h0000) else $error("off mode kept capture");
    AST_IRQ: assert property (@(posedge clk) disable iff (rst) // RQ4
        capture_event && enable_q && !wr_enable |=> irq) else $error("irq missing after enabled capture");

    // ****************************************
    // edge mode, register, prescaler and flag assertions
    // ****************************************
    // the result, step, clear, pair hold and byte read checks lean on the named steps below, so each reads as the behaviour it guards
    // a rising edge that the prescaler counts
    sequence s_counted_rise;
        edge_rise && ((mode_select_field == CCPCU_MODE_RISE4) || (mode_select_field == CCPCU_MODE_RISE16));
    endsequence

    // a software clear with no capture beside it, so the clear must win
    sequence s_clear_alone;
        wr_clear && reg_wdata[CCPCU_FLAG_CAPTURE] && !capture_event;
    endsequence

    // a cycle in which the capture pair has no reason to change
    sequence s_pair_quiet;
        !capture_event && !mode_off;
    endsequence

    // read strobes aimed at the two capture bytes
    sequence s_read_low;
        reg_rd && (reg_addr == CCPCU_ADDR_CAPT_LOW);
    endsequence

    sequence s_read_high;
        reg_rd && (reg_addr == CCPCU_ADDR_CAPT_HIGH);
    endsequence

    // what a capture leaves one cycle later: the timer copy and a raised flag
    sequence s_capture_result;
        flag_q && (capture_q == $past(timer_one_count));
    endsequence

    // RQ3 falling edge taken
    AST_FALL_CAPT: assert property (@(posedge clk) disable iff (rst) // RQ3
        mode_select_field == CCPCU_MODE_FALL && edge_fall |-> capture_event) else $error("fall edge missed");

    // RQ3 rise mode ignores falls
    AST_RISE_ONLY: assert property (@(posedge clk) disable iff (rst) // RQ3
        mode_select_field == CCPCU_MODE_RISE && edge_fall |-> !capture_event) else $error("fall captured");

    // RQ1 rise mode result
    // value and flag are checked together, since software reads both after the interrupt
    AST_RISE_RESULT: assert property (@(posedge clk) disable iff (rst) // RQ1
        mode_select_field == CCPCU_MODE_RISE && edge_rise |=> s_capture_result)
        else $error("rise capture incomplete");

    // RQ2 fourth counted rise
    AST_PRE4: assert property (@(posedge clk) disable iff (rst) // RQ2
        capture_event && mode_select_field == CCPCU_MODE_RISE4 |-> pre_q[1:0] == CCPCU_PRE4_LAST[1:0])
        else $error("4th edge wrong");

    // RQ2 counted rise steps count
    // the count wraps through all sixteen values in both modes, which is why a switch keeps its phase
    AST_PRE_STEP: assert property (@(posedge clk) disable iff (rst) // RQ2
        s_counted_rise |=> pre_q == $past(pre_q) + CCPCU_PRE_ONE) else $error("prescaler did not step");

    // RQ11 no event outside capture
    AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (rst) // RQ11
        !capture_mode |-> !capture_event) else $error("event outside capture mode");

    // RQ12 reset clears counter
    // checked at the first edge after release; a disable on reset here would hide the check
    AST_RST_PRE: assert property (@(posedge clk) // RQ12
        $fell(rst) |-> pre_q == CCPCU_PRE_ZERO) else $error("prescaler not cleared by reset");

    // RQ5 software clear works
    AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (rst) // RQ5
        s_clear_alone |=> !flag_q) else $error("flag clear ignored");

    // RQ4 flag rises on capture only
    // any other source would be a false interrupt that software cannot tell from a real one
    AST_FLAG_CAUSE: assert property (@(posedge clk) disable iff (rst) // RQ4
        !flag_q && !capture_event |=> !flag_q) else $error("flag set without capture");

    // RQ6 pair holds between captures
    AST_PAIR_HOLD: assert property (@(posedge clk) disable iff (rst) // RQ6
        s_pair_quiet |=> capture_q == $past(capture_q)) else $error("capture pair changed alone");

    // RQ1 low byte read
    AST_RD_LOW: assert property (@(posedge clk) disable iff (rst) // RQ1
        s_read_low |=> reg_rdata == $past(capture_q[7:0])) else $error("capture low read wrong");

    // RQ1 high byte read
    AST_RD_HIGH: assert property (@(posedge clk) disable iff (rst) // RQ1
        s_read_high |=> reg_rdata == $past(capture_q[15:8])) else $error("capture high read wrong");

    // RQ16 control read back
    AST_RD_CONTROL: assert property (@(posedge clk) disable iff (rst) // RQ16
        reg_rd && reg_addr == CCPCU_ADDR_CONTROL |=> reg_rdata == $past(control_q))
        else $error("control read wrong");

    // RQ16 top bits stay zero
    AST_CTRL_TOP: assert property (@(posedge clk) disable iff (rst) // RQ16
        (control_q & ~CCPCU_CONTROL_MASK) == 8'h00) else $error("unimplemented control bits set");

    // RQ16 mode follows write
    AST_MODE_WRITE: assert property (@(posedge clk) disable iff (rst) // RQ16
        wr_control |=> mode_select_field == $past(reg_wdata[CCPCU_MODE_MSB:CCPCU_MODE_LSB]))
        else $error("mode field not written");

    // RQ15 duty follows write
    // these bits only matter to the pwm side, but they must still store and read back in capture mode
    AST_DUTY_WRITE: assert property (@(posedge clk) disable iff (rst) // RQ15
        wr_control |=> pwm_duty_low_bits == $past(reg_wdata[CCPCU_DUTY_MSB:CCPCU_DUTY_LSB]))
        else $error("duty bits not written");
endmodule
`default_nettype wire

// ==== ccpcu_pin_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************
// event source on the capture pin
// ****************
module ccpcu_pin_model (
    input wire logic clk,
    output logic level
);
    initial begin
        level = 1'b0;
    end
    // pin driven from outside
    // each level is held six cycles so the two-flop sync never misses it
    task automatic drive(input logic v);
        begin
            @(posedge clk);
            level <= v;
            repeat (6) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ==== ccpcu_capture_unit_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module ccpcu_capture_unit_tb;
    import ccpcu_pkg::*;
    logic clk, rst, reg_wr, reg_rd, pin_oe, pin_out, pin_lvl, irq;
    logic [3:0] reg_addr, mode_o;
    logic [7:0] reg_wdata, reg_rdata;
    logic [15:0] tmr;
    logic [1:0] duty_o;
    wire logic pin_wire;
    integer err_total, compares, seed, cycles, pre, flag, ena, mode, i, t;
    // captures the model expects, oldest first; only the newest may stand in the pair
    integer caps[$];
    // wire level: the unit wins only while it enables its driver
    assign pin_wire = pin_oe ? pin_out : pin_lvl;
    ccpcu_capture_unit dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_one_count(tmr),
        .capture_pin_in(pin_wire), .capture_pin_out(pin_out), .capture_pin_oe(pin_oe),
        .mode_select_field(mode_o), .pwm_duty_low_bits(duty_o), .irq(irq));
    ccpcu_pin_model src (.clk(clk), .level(pin_lvl));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard, far above the roughly nine hundred cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            end_sim;
        end
    end
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        begin
            @(posedge clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input integer exp);
        begin
            @(posedge clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1;
            chk({8'h00, reg_rdata}, exp[15:0]);
        end
    endtask
    // flag is cleared after every mode change, since a change may raise a false one
    task automatic set_mode(input logic [3:0] m, input logic [1:0] d);
        begin
            wr(CCPCU_ADDR_CONTROL, {2'h0, d, m});
            wr(CCPCU_ADDR_CLEAR, 8'h01);
            mode = m;
            flag = 0;
            if (m < 4 || m > 7) pre = 0;
            if (m == 0) caps.delete();
        end
    endtask
    // one pin level change with a fresh timer value, then model compare
    task automatic ev(input logic v);
        logic hit;
        begin
            @(posedge clk);
            t = $random(seed);
            // timer steps on our own clock edge, as synchronous counting needs
            tmr <= t[15:0];
            hit = 1'b0;
            if (mode == 4 && !v && pin_lvl) hit = 1'b1;
            if (v && !pin_lvl) begin
                if (mode == 5) hit = 1'b1;
                if (mode == 6 && pre % 4 == 3) hit = 1'b1;
                if (mode == 7 && pre == 15) hit = 1'b1;
                if (mode == 6 || mode == 7) pre = (pre + 1) % 16;
            end
            if (hit) begin
                caps.push_back(t & 65535);
                flag = 1;
            end
            src.drive(v);
            rd(CCPCU_ADDR_STATUS, pre);
            rd(CCPCU_ADDR_FLAGS, flag);
            chk({15'h0, irq}, 16'(flag & ena));
        end
    endtask
    task automatic cap_chk;
        integer c;
        begin
            c = (caps.size() > 0) ? caps[$] : 0;
            rd(CCPCU_ADDR_CAPT_LOW, c % 256);
            rd(CCPCU_ADDR_CAPT_HIGH, c / 256);
        end
    endtask
    task automatic end_sim;
        begin
            if (err_total == 0 && compares > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        {err_total, compares, cycles, pre, flag, ena, mode} = '0;
        seed = 25;
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata, tmr} = {3'b100, 28'h0};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(CCPCU_ADDR_CONTROL, 0);
        set_mode(4'hf, 2'h3);
        rd(CCPCU_ADDR_CONTROL, 8'h3f);
        chk({12'h0, mode_o}, 16'hf);
        // compare mode: edges ignored, prescaler stays clear
        set_mode(4'h8, 2'h0);
        for (i = 0; i < 4; i++) ev(~i[0]);
        wr(CCPCU_ADDR_ENABLE, 8'h01);
        ena = 1;
        set_mode(CCPCU_MODE_FALL, 2'h2);
        chk({14'h0, duty_o}, 16'h2);
        // a rise first, which falling mode must ignore, then the fall that captures
        ev(1'b1);
        ev(1'b0);
        cap_chk;
        wr(CCPCU_ADDR_CLEAR, 8'h00);
        rd(CCPCU_ADDR_FLAGS, 1);
        wr(CCPCU_ADDR_ENABLE, 8'h00);
        ena = 0;
        // let the enable update settle before looking at irq
        #1;
        chk({15'h0, irq}, 16'h0);
        wr(CCPCU_ADDR_CLEAR, 8'h01);
        rd(CCPCU_ADDR_FLAGS, 0);
        wr(CCPCU_ADDR_ENABLE, 8'h01);
        ena = 1;
        // two captures before the pair is read: the later value must stand
        set_mode(CCPCU_MODE_RISE, 2'h0);
        for (i = 0; i < 3; i++) ev(~i[0]);
        cap_chk;
        set_mode(CCPCU_MODE_RISE4, 2'h1);
        for (i = 0; i < 16; i++) ev(i[0]);
        cap_chk;
        // module off before the new prescale
        set_mode(CCPCU_MODE_OFF, 2'h0);
        set_mode(CCPCU_MODE_RISE16, 2'h0);
        for (i = 0; i < 36; i++) ev(i[0]);
        cap_chk;
        // prescale switch without turning off keeps the count of 2
        set_mode(CCPCU_MODE_RISE4, 2'h0);
        for (i = 0; i < 4; i++) ev(i[0]);
        cap_chk;
        set_mode(CCPCU_MODE_OFF, 2'h0);
        rd(CCPCU_ADDR_STATUS, 0);
        cap_chk;
        chk({15'h0, pin_oe}, 16'h0);
        set_mode(CCPCU_MODE_RISE16, 2'h0);
        for (i = 0; i < 2; i++) ev(i[0]);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        {pre, ena, mode, flag} = '0;
        caps.delete();
        rd(CCPCU_ADDR_STATUS, 0);
        rd(CCPCU_ADDR_CONTROL, 0);
        cap_chk;
        // read-only and unmapped places
        wr(CCPCU_ADDR_CAPT_LOW, 8'h5a);
        rd(CCPCU_ADDR_CAPT_LOW, 0);
        rd(4'h9, 0);
        end_sim;
    end
endmodule
`default_nettype wire
